// File: hw/apc_pkg.sv
// constants and carrier types for the axis position compensation block
// assumes a 125 MHz system clock and encoder counters on that same clock
package apc_pkg;
  // ==========================================================
  // register map (byte addresses, one aligned word each)
  localparam logic [9:0] OFS_CTRL = 10'h000;
  localparam logic [9:0] OFS_CMD = 10'h004;
  localparam logic [9:0] OFS_STATUS = 10'h008;
  localparam logic [9:0] OFS_ENC = 10'h00C;
  // per-axis block: 0x100 + axis*0x40 + index*4
  localparam logic [1:0] AXIS_BLK = 2'h1;
  localparam logic [3:0] AR_DISP = 4'h0;
  localparam logic [3:0] AR_MODE = 4'h1;
  localparam logic [3:0] AR_PPM = 4'h2;
  localparam logic [3:0] AR_START = 4'h3;
  localparam logic [3:0] AR_SPACE = 4'h4;
  localparam logic [3:0] AR_BLASH = 4'h5;
  localparam logic [3:0] AR_POS = 4'h6;
  localparam logic [3:0] AR_TIDX = 4'h7;
  localparam logic [3:0] AR_TDATA = 4'h8;
  // ==========================================================
  // field positions
  localparam int CTRL_TURN = 0;
  localparam int CTRL_THREE = 1;
  localparam int CMD_DFLT = 0;
  localparam int CMD_YES = 1;
  localparam int CMD_NO = 2;
  localparam int CMD_CAPT = 3;
  localparam int CMD_CAPT_AX = 4;
  localparam logic [1:0] COMP_OFF = 2'h0;
  localparam logic [1:0] COMP_LIN = 2'h1;
  localparam logic [1:0] COMP_NL = 2'h2;
  localparam logic [1:0] NV_OFF = 2'h0;
  localparam logic [1:0] NV_AUX = 2'h1;
  localparam logic [1:0] NV_MAIN = 2'h2;
  localparam int AUX_DISP = 1;
  localparam int MAIN_DISP = 2;
  localparam logic [2:0] LBL_Z0 = 3'h3;
  localparam logic signed [63:0] PPM_SCALE = 64'sh00000000000F4240;
  // ==========================================================
  // timing
  localparam int KEY_HOLD_MS = 2000;
  localparam int CLK_KHZ = 125000;
  localparam int KEY_HOLD_CYC = KEY_HOLD_MS * CLK_KHZ;
  // ==========================================================
  // types
  typedef logic signed [31:0] pos_t;
  typedef enum logic [2:0] {Z_OFF = 3'h1, Z_AUX = 3'h2, Z_MAIN = 3'h4} zmode_t;
  typedef struct packed {
    logic [1:0] cpl_sel;
    logic cpl_neg;
    logic cpl_en;
    logic [3:0] res;
    logic [1:0] in_sel;
    logic [2:0] label;
    logic en;
  } disp_cfg_t;
  typedef struct packed {
    logic [1:0] mode;
    pos_t ppm;
    pos_t start;
    logic [4:0] shift;
    logic [7:0] npts;
    pos_t backlash;
  } comp_cfg_t;
  typedef struct packed {
    pos_t pos;
    logic ref_pulse;
  } enc_in_t;
  typedef struct packed {
    pos_t pos;
    logic blank;
    logic coupled;
    logic datum_ok;
  } disp_out_t;
endpackage

// File: hw/axis_position_compensation.sv
// per-axis position processing: coupling, linear/table correction, backlash
// assumes encoder counters on clk_sys, counts relative to the reference point
// Function
// - display sums or subtracts a second encoder input and flags itself coupled.
// - two-second auxiliary key hold shows the sum there and blanks main.
// - two-second main key hold shows the sum there and blanks auxiliary.
// - coupling state is written to non-volatile storage and restored at start.
// - coupled position is recomputed every cycle from both inputs.
// - coupled datum restore is allowed only after both reference marks.
// - pressing the key of the blanked display cancels coupling.
// - each axis owns its own compensation type and parameters.
// - ppm and table compensation run only for encoders configured linear; backlash applies to any encoder.
// - linear mode scales position by a signed ppm factor.
// - table mode holds up to 200 points per axis, linearly interpolated.
// - table correction waits for the reference mark; needs encoders with marks.
// - points are uniformly spaced from a configurable start point.
// - start point is referenced to the mark and can be captured.
// - a signed backlash value is accepted; positive means encoder ahead.
// - negative backlash covers an encoder lagging the table.
// - backlash of zero disables backlash correction.
// - active axis count is two or three.
// - confirmed factory default restores the set for milling or turning.
// - each display has enable, label, input and resolution settings.
`timescale 1ns/1ps
module axis_position_compensation #(
  parameter int POINTS = 200,
  parameter int unsigned HOLD_CYCLES = apc_pkg::KEY_HOLD_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input apc_pkg::enc_in_t [2:0] enc,
  input wire logic key_aux_pin,
  input wire logic key_main_pin,
  input wire logic [1:0] nv_cpl_in,
  output logic [1:0] nv_cpl_out,
  output logic nv_cpl_we,
  output apc_pkg::disp_out_t [2:0] disp
);
  // ==========================================================
  // types and checks
  typedef logic signed [15:0] corr_t;
  typedef struct packed {
    apc_pkg::disp_cfg_t [2:0] dcfg;
    apc_pkg::comp_cfg_t [2:0] ccfg;
    corr_t [2:0][POINTS-1:0] tbl;
    logic turn;
    logic three;
    logic [2:0] enc_lin;
    logic [2:0] enc_ref;
    logic [2:0][7:0] tidx;
    apc_pkg::zmode_t zmode;
    logic dflt_pend;
    logic [2:0] ref_seen;
    logic [2:0] rev;
    apc_pkg::pos_t [2:0] last;
    logic [1:0] k1;
    logic [1:0] k2;
    logic [1:0] k3;
    logic [1:0][31:0] hcnt;
    logic booted;
    logic wreq;
    logic [31:0] rdata;
    logic [1:0] nv;
    logic nv_we;
    apc_pkg::disp_out_t [2:0] dout;
  } st_t;

  localparam logic [31:0] HOLD_M1 = 32'(HOLD_CYCLES - 1);
  localparam logic [31:0] HOLD_MAX = 32'(HOLD_CYCLES);

  if (POINTS < 2 || POINTS > 256) begin : g_bad_points
    $error("POINTS must lie in 2..256");
  end
  if (HOLD_CYCLES < 2) begin : g_bad_hold
    $error("HOLD_CYCLES must be at least 2");
  end

  // ==========================================================
  // helpers
  function automatic logic pick(input logic [2:0] v, input logic [1:0] s);
    pick = (s == 2'h3) ? 1'b0 : v[s];
  endfunction

  function automatic apc_pkg::pos_t epos(input apc_pkg::enc_in_t [2:0] e,
                                         input logic [1:0] s);
    epos = (s == 2'h3) ? '0 : e[s].pos;
  endfunction

  function automatic logic [1:0] nv_code(input apc_pkg::zmode_t z);
    nv_code = (z == apc_pkg::Z_AUX) ? apc_pkg::NV_AUX :
              (z == apc_pkg::Z_MAIN) ? apc_pkg::NV_MAIN : apc_pkg::NV_OFF;
  endfunction

  // ppm correction; 64-bit product keeps full range before the divide
  function automatic apc_pkg::pos_t lin_corr(input apc_pkg::pos_t raw,
                                             input apc_pkg::pos_t ppm);
    lin_corr = apc_pkg::pos_t'((64'(raw) * 64'(ppm)) / apc_pkg::PPM_SCALE);
  endfunction

  // spacing is a power of two so the index is a shift, not a divider
  function automatic apc_pkg::pos_t nl_corr(input corr_t [POINTS-1:0] t,
                                            input apc_pkg::comp_cfg_t c,
                                            input apc_pkg::pos_t raw);
    apc_pkg::pos_t rel;
    apc_pkg::pos_t d;
    logic [31:0] idx;
    logic [31:0] frac;
    logic signed [63:0] p;
    int last;
    rel = raw - c.start;
    last = (int'(c.npts) < 2) ? 0 : ((int'(c.npts) > POINTS) ? POINTS : int'(c.npts)) - 1;
    idx = 32'(rel >>> c.shift);
    frac = 32'(rel) & ((32'h1 << c.shift) - 32'h1);
    if (rel < 0 || last == 0) begin
      nl_corr = apc_pkg::pos_t'(t[0]);
    end else if (idx >= 32'(last)) begin
      nl_corr = apc_pkg::pos_t'(t[last]);
    end else begin
      d = apc_pkg::pos_t'(t[idx + 1]) - apc_pkg::pos_t'(t[idx]);
      p = 64'(d) * 64'({32'h0, frac});
      nl_corr = apc_pkg::pos_t'(t[idx]) + apc_pkg::pos_t'(p >>> c.shift);
    end
  endfunction

  function automatic st_t with_defaults(input st_t s, input logic turn);
    st_t r;
    r = s;
    for (int d = 0; d < 3; d++) begin
      r.dcfg[d] = '0;
      r.dcfg[d].en = 1'b1;
      r.dcfg[d].in_sel = 2'(d);
      r.dcfg[d].label = (turn && d == apc_pkg::AUX_DISP) ? apc_pkg::LBL_Z0 : 3'(d);
      r.ccfg[d] = '0;
      r.tbl[d] = '0;
    end
    r.turn = turn;
    r.three = 1'b1;
    r.zmode = apc_pkg::Z_OFF;
    r.dflt_pend = 1'b0;
    return r;
  endfunction

  function automatic st_t rst_state();
    st_t r;
    r = with_defaults('0, 1'b0);
    r.wreq = 1'b1;
    return r;
  endfunction

  localparam st_t ST_RST = rst_state();

  st_t st;
  st_t next_st;
  logic [1:0] hold;
  logic [1:0] rise;

  // ==========================================================
  // key hold and press detection
  for (genvar k = 0; k < 2; k++) begin : g_key
    assign hold[k] = st.k2[k] && (st.hcnt[k] == HOLD_M1);
    assign rise[k] = st.k2[k] && !st.k3[k];
  end

  // ==========================================================
  // next state
  always_comb begin
    apc_pkg::pos_t [2:0] raw;
    apc_pkg::pos_t zsum;
    apc_pkg::pos_t cp;
    logic [2:0] okb;
    logic [31:0] rv;
    logic [31:0] wv;
    logic [31:0] mask;
    logic [1:0] ax;
    logic [1:0] isel;
    logic [3:0] ar;
    logic wacc;
    logic inaxis;
    logic zc;
    logic rv_n;
    apc_pkg::zmode_t zn;
    next_st = st;
    raw = '0;
    zsum = '0;
    cp = '0;
    okb = '0;
    rv = '0;
    wv = '0;
    zn = apc_pkg::Z_OFF;
    ax = avs_address[7:6];
    ar = avs_address[5:2];
    isel = '0;
    zc = 1'b0;
    rv_n = 1'b0;
    inaxis = avs_address[9:8] == apc_pkg::AXIS_BLK && ax != 2'h3 && avs_address[1:0] == 2'h0;
    wacc = avs_write && !st.wreq;
    mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // register readback; unmapped words read zero
    if (avs_address == apc_pkg::OFS_CTRL) begin
      rv = 32'({st.three, st.turn});
    end else if (avs_address == apc_pkg::OFS_STATUS) begin
      rv = 32'({st.ref_seen, st.dflt_pend, st.zmode});
    end else if (avs_address == apc_pkg::OFS_ENC) begin
      rv = 32'({st.enc_ref, st.enc_lin});
    end else if (inaxis) begin
      case (ar)
        apc_pkg::AR_DISP: rv = 32'(st.dcfg[ax]);
        apc_pkg::AR_MODE: rv = 32'(st.ccfg[ax].mode);
        apc_pkg::AR_PPM: rv = st.ccfg[ax].ppm;
        apc_pkg::AR_START: rv = st.ccfg[ax].start;
        apc_pkg::AR_SPACE: rv = 32'({st.ccfg[ax].npts, st.ccfg[ax].shift});
        apc_pkg::AR_BLASH: rv = st.ccfg[ax].backlash;
        apc_pkg::AR_POS: rv = st.dout[ax].pos;
        apc_pkg::AR_TIDX: rv = 32'(st.tidx[ax]);
        apc_pkg::AR_TDATA: begin
          if ({1'b0, st.tidx[ax]} < 9'(POINTS)) begin
            rv = apc_pkg::pos_t'(st.tbl[ax][st.tidx[ax]]);
          end
        end
        default: rv = '0;
      endcase
    end
    wv = (rv & ~mask) | (avs_writedata & mask);

    // bus: one wait state, read data captured on the first cycle
    next_st.wreq = !((avs_read || avs_write) && st.wreq);
    if (avs_read && st.wreq) begin
      next_st.rdata = rv;
    end

    // raw positions with optional two-input coupling
    for (int d = 0; d < 3; d++) begin
      isel = st.dcfg[d].in_sel;
      raw[d] = epos(enc, isel);
      okb[d] = pick(st.ref_seen, isel);
      if (st.dcfg[d].cpl_en) begin
        raw[d] = st.dcfg[d].cpl_neg ? raw[d] - epos(enc, st.dcfg[d].cpl_sel) :
                                      raw[d] + epos(enc, st.dcfg[d].cpl_sel);
        okb[d] = okb[d] && pick(st.ref_seen, st.dcfg[d].cpl_sel);
      end
    end
    zsum = raw[apc_pkg::AUX_DISP] + raw[apc_pkg::MAIN_DISP];
    if (st.zmode == apc_pkg::Z_AUX) begin
      raw[apc_pkg::AUX_DISP] = zsum;
    end
    if (st.zmode == apc_pkg::Z_MAIN) begin
      raw[apc_pkg::MAIN_DISP] = zsum;
    end

    // bus writes
    if (wacc) begin
      if (avs_address == apc_pkg::OFS_CTRL) begin
        next_st.turn = wv[apc_pkg::CTRL_TURN];
        next_st.three = wv[apc_pkg::CTRL_THREE];
      end
      if (avs_address == apc_pkg::OFS_ENC) begin
        next_st.enc_lin = wv[2:0];
        next_st.enc_ref = wv[5:3];
      end
      if (avs_address == apc_pkg::OFS_CMD) begin
        if (wv[apc_pkg::CMD_YES] && st.dflt_pend) begin
          next_st = with_defaults(next_st, st.turn);
        end else if (wv[apc_pkg::CMD_NO]) begin
          next_st.dflt_pend = 1'b0;
        end else if (wv[apc_pkg::CMD_DFLT]) begin
          next_st.dflt_pend = 1'b1;
        end
        if (wv[apc_pkg::CMD_CAPT] && wv[apc_pkg::CMD_CAPT_AX +: 2] != 2'h3) begin
          next_st.ccfg[wv[apc_pkg::CMD_CAPT_AX +: 2]].start =
            raw[wv[apc_pkg::CMD_CAPT_AX +: 2]];
        end
      end
      if (inaxis) begin
        isel = st.dcfg[ax].in_sel;
        case (ar)
          apc_pkg::AR_DISP: next_st.dcfg[ax] = apc_pkg::disp_cfg_t'(wv[13:0]);
          apc_pkg::AR_MODE: begin
            next_st.ccfg[ax].mode = wv[1:0];
            if (!pick(st.enc_lin, isel) || wv[1:0] == 2'h3 ||
                (wv[1:0] == apc_pkg::COMP_NL && !pick(st.enc_ref, isel))) begin
              next_st.ccfg[ax].mode = apc_pkg::COMP_OFF;
            end
          end
          apc_pkg::AR_PPM: next_st.ccfg[ax].ppm = wv;
          apc_pkg::AR_START: next_st.ccfg[ax].start = wv;
          apc_pkg::AR_SPACE: begin
            next_st.ccfg[ax].shift = wv[4:0];
            next_st.ccfg[ax].npts = wv[12:5];
          end
          apc_pkg::AR_BLASH: next_st.ccfg[ax].backlash = wv;
          apc_pkg::AR_TIDX: next_st.tidx[ax] = wv[7:0];
          apc_pkg::AR_TDATA: begin
            if ({1'b0, st.tidx[ax]} < 9'(POINTS)) begin
              next_st.tbl[ax][st.tidx[ax]] = wv[15:0];
            end
          end
          default: ;
        endcase
      end
    end

    // reference marks are sticky until reset
    for (int e = 0; e < 3; e++) begin
      next_st.ref_seen[e] = st.ref_seen[e] || enc[e].ref_pulse;
    end

    // compensation and display outputs
    for (int d = 0; d < 3; d++) begin
      isel = st.dcfg[d].in_sel;
      cp = raw[d];
      if (pick(st.enc_lin, isel)) begin
        if (st.ccfg[d].mode == apc_pkg::COMP_LIN) begin
          cp = raw[d] + lin_corr(raw[d], st.ccfg[d].ppm);
        end else if (st.ccfg[d].mode == apc_pkg::COMP_NL && pick(st.enc_ref, isel) &&
                     pick(st.ref_seen, isel)) begin
          cp = raw[d] + nl_corr(st.tbl[d], st.ccfg[d], raw[d]);
        end
      end
      rv_n = st.rev[d];
      if (raw[d] < st.last[d]) begin
        rv_n = 1'b1;
      end else if (raw[d] > st.last[d]) begin
        rv_n = 1'b0;
      end
      next_st.rev[d] = rv_n;
      next_st.last[d] = raw[d];
      // zero backlash adds nothing, so no separate disable
      if (rv_n) begin
        cp = cp + st.ccfg[d].backlash;
      end
      zc = (st.zmode == apc_pkg::Z_AUX && d == apc_pkg::AUX_DISP) ||
           (st.zmode == apc_pkg::Z_MAIN && d == apc_pkg::MAIN_DISP);
      next_st.dout[d].pos = cp;
      next_st.dout[d].coupled = st.dcfg[d].cpl_en || zc;
      next_st.dout[d].datum_ok = zc ? okb[apc_pkg::AUX_DISP] && okb[apc_pkg::MAIN_DISP] :
                                      okb[d];
      next_st.dout[d].blank = !st.dcfg[d].en || (d == 2 && !st.three) ||
        (st.zmode == apc_pkg::Z_AUX && d == apc_pkg::MAIN_DISP) ||
        (st.zmode == apc_pkg::Z_MAIN && d == apc_pkg::AUX_DISP);
    end

    // key synchronisers and hold counters
    next_st.k1 = {key_main_pin, key_aux_pin};
    next_st.k2 = st.k1;
    next_st.k3 = st.k2;
    for (int k = 0; k < 2; k++) begin
      if (!st.k2[k]) begin
        next_st.hcnt[k] = '0;
      end else if (st.hcnt[k] != HOLD_MAX) begin
        next_st.hcnt[k] = st.hcnt[k] + 32'h1;
      end
    end

    // coupling mode; only a three-axis turning setup offers it
    zn = next_st.zmode;
    if (!st.booted) begin
      zn = (nv_cpl_in == apc_pkg::NV_AUX) ? apc_pkg::Z_AUX :
           (nv_cpl_in == apc_pkg::NV_MAIN) ? apc_pkg::Z_MAIN : apc_pkg::Z_OFF;
      next_st.booted = 1'b1;
    end else if (st.turn && st.three) begin
      unique case (st.zmode)
        apc_pkg::Z_OFF: begin
          if (hold[0]) begin
            zn = apc_pkg::Z_AUX;
          end else if (hold[1]) begin
            zn = apc_pkg::Z_MAIN;
          end
        end
        apc_pkg::Z_AUX: begin
          if (rise[1]) begin
            zn = apc_pkg::Z_OFF;
          end else if (hold[1]) begin
            zn = apc_pkg::Z_MAIN;
          end
        end
        apc_pkg::Z_MAIN: begin
          if (rise[0]) begin
            zn = apc_pkg::Z_OFF;
          end else if (hold[0]) begin
            zn = apc_pkg::Z_AUX;
          end
        end
        default: zn = apc_pkg::Z_OFF;
      endcase
    end
    next_st.zmode = zn;
    next_st.nv_we = st.booted && (zn != st.zmode);
    if (next_st.nv_we) begin
      next_st.nv = nv_code(zn);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata = st.rdata;
  assign avs_waitrequest = st.wreq;
  assign nv_cpl_out = st.nv;
  assign nv_cpl_we = st.nv_we;
  assign disp = st.dout;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest) else $error("bus answer not after one wait cycle");
  a_aux_hold_enter: assert property (st.booted && st.turn && st.three &&
    st.zmode == apc_pkg::Z_OFF && hold[0] |=> st.zmode == apc_pkg::Z_AUX)
    else $error("aux hold did not couple");
  a_aux_blank_main: assert property (st.zmode == apc_pkg::Z_AUX |=>
    disp[apc_pkg::MAIN_DISP].blank && disp[apc_pkg::AUX_DISP].coupled)
    else $error("aux coupling display wrong");
  a_main_hold_enter: assert property (st.booted && st.turn && st.three &&
    st.zmode == apc_pkg::Z_OFF && !hold[0] && hold[1] |=> st.zmode == apc_pkg::Z_MAIN)
    else $error("main hold did not couple");
  a_main_blank_aux: assert property (st.zmode == apc_pkg::Z_MAIN |=>
    disp[apc_pkg::AUX_DISP].blank && disp[apc_pkg::MAIN_DISP].coupled)
    else $error("main coupling display wrong");
  a_nv_mode_save: assert property ($past(st.booted) && $changed(st.zmode) |->
    nv_cpl_we && nv_cpl_out == nv_code(st.zmode)) else $error("coupling not saved");
  a_cancel_aux: assert property (st.booted && st.turn && st.three &&
    st.zmode == apc_pkg::Z_AUX && rise[1] |=> st.zmode == apc_pkg::Z_OFF)
    else $error("blank key did not cancel");
  a_datum_gate: assert property ($past(st.zmode) != apc_pkg::Z_OFF &&
    $past(st.ref_seen) == 3'h0 |-> !disp[apc_pkg::AUX_DISP].datum_ok &&
    !disp[apc_pkg::MAIN_DISP].datum_ok)
    else $error("datum allowed without marks");
  a_rev_on_drop: assert property ($rose(st.rev[0]) |->
    st.last[0] < $past(st.last[0])) else $error("reversal without decrease");
  a_two_axes: assert property (!st.three |=> disp[2].blank)
    else $error("third display shown with two axes");
  a_dflt_apply: assert property (avs_write && !avs_waitrequest && st.dflt_pend &&
    avs_address == apc_pkg::OFS_CMD && avs_byteenable[0] &&
    avs_writedata[apc_pkg::CMD_YES] |=> st.three && !st.dflt_pend &&
    st.zmode == apc_pkg::Z_OFF) else $error("factory default not applied");
endmodule

// File: test/enc_model.sv
// incremental encoder stand-in: counter walking one count a cycle to a target
// assumes the same clock as the block; reference mark at a fixed count
`timescale 1ns/1ps
module enc_model #(
  parameter int REF_AT = 5
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input apc_pkg::pos_t tgt,
  output apc_pkg::enc_in_t enc
);
  // ==========================================================
  // motion: real scales never jump, so step one count at a time
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      enc <= '0;
    end else if (enc.pos != tgt) begin
      enc.pos <= (tgt > enc.pos) ? enc.pos + 1 : enc.pos - 1;
      enc.ref_pulse <= ((tgt > enc.pos ? enc.pos + 1 : enc.pos - 1) == REF_AT);
    end else begin
      enc.ref_pulse <= 1'b0;
    end
  end
endmodule

// File: test/axis_position_compensation_bench.sv
// register-level bench for the position compensation block
// assumes three encoder models and an Avalon master with one wait state
`timescale 1ns/1ps
module axis_position_compensation_bench;
  localparam int HOLD = 16;
  logic clk_sys, nrst, avs_read, avs_write, avs_waitrequest, key_aux_pin, key_main_pin;
  logic nv_cpl_we;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [1:0] nv_cpl_in, nv_cpl_out;
  logic [1:0] nv_last = 2'h0;
  wire apc_pkg::enc_in_t [2:0] enc;
  apc_pkg::disp_out_t [2:0] disp;
  apc_pkg::pos_t tgt [3];
  int fails, compares, c;
  int nv_cnt = 0;
  logic signed [31:0] bl [3] = '{50, -50, 0};
  axis_position_compensation #(.HOLD_CYCLES(HOLD)) DUT (.clk_sys(clk_sys), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .enc(enc), .key_aux_pin(key_aux_pin),
    .key_main_pin(key_main_pin), .nv_cpl_in(nv_cpl_in), .nv_cpl_out(nv_cpl_out),
    .nv_cpl_we(nv_cpl_we), .disp(disp));
  for (genvar i = 0; i < 3; i++) begin : g_enc
    enc_model u_enc (.clk_sys(clk_sys), .nrst(nrst), .tgt(tgt[i]), .enc(enc[i]));
  end
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (nv_cpl_we === 1'b1) begin
      nv_cnt++;
      nv_last <= nv_cpl_out;
    end
  end
  // ==========================================================
  // tasks
  task automatic results();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic die();
    fails++;
    $display("ERROR t=%0t wait ran out", $time);
    results();
  endtask
  // one bus access; held until waitrequest is seen low at an edge
  task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 20) die();
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic go(input int i, input int v);
    int n;
    tgt[i] <= v;
    for (n = 0; n < 2000; n++) begin
      @(posedge clk_sys);
      if (enc[i].pos === v) break;
    end
    if (n == 2000) die();
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic key(input logic m, input int n);
    if (m) key_main_pin <= 1'b1;
    else key_aux_pin <= 1'b1;
    repeat (n) @(posedge clk_sys);
    key_main_pin <= 1'b0;
    key_aux_pin <= 1'b0;
    repeat (8) @(posedge clk_sys);
    acc(0, apc_pkg::OFS_STATUS, 0);
  endtask
  function automatic logic [9:0] pa(input int a, input logic [3:0] r);
    return 10'(256 + a * 64 + r * 4);
  endfunction
  // ==========================================================
  // main sequence
  initial begin
    {nrst, avs_read, avs_write, key_aux_pin, key_main_pin, avs_address} = '0;
    {avs_writedata, nv_cpl_in, fails, compares} = '0;
    tgt = '{0, 0, 0};
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    acc(0, apc_pkg::OFS_CTRL, 0); chk(q, 32'h2);
    acc(0, 10'h0FC, 0); chk(q, 32'h0);
    acc(1, apc_pkg::OFS_ENC, 32'h3B);
    acc(1, pa(2, apc_pkg::AR_MODE), 1);
    acc(0, pa(2, apc_pkg::AR_MODE), 0); chk(q, 32'h0);
    acc(1, pa(0, apc_pkg::AR_MODE), 1);
    acc(1, pa(0, apc_pkg::AR_PPM), 1000);
    go(0, 1000);
    acc(0, pa(0, apc_pkg::AR_POS), 0); chk(q, 1001);
    acc(1, pa(0, apc_pkg::AR_PPM), -2000);
    acc(0, pa(0, apc_pkg::AR_POS), 0); chk(q, 998);
    acc(1, pa(1, apc_pkg::AR_SPACE), 32'h63);
    for (int i = 0; i < 3; i++) begin
      acc(1, pa(1, apc_pkg::AR_TIDX), i);
      acc(1, pa(1, apc_pkg::AR_TDATA), 16 * i);
    end
    acc(1, pa(1, apc_pkg::AR_MODE), 2);
    go(1, 4);
    acc(0, pa(1, apc_pkg::AR_POS), 0); chk(q, 4);
    go(1, 20);
    acc(0, pa(1, apc_pkg::AR_POS), 0); chk(q, 52);
    go(1, 12);
    acc(0, pa(1, apc_pkg::AR_POS), 0); chk(q, 36);
    acc(1, apc_pkg::OFS_CMD, 32'h18);
    acc(0, pa(1, apc_pkg::AR_START), 0); chk(q, 12);
    acc(0, pa(1, apc_pkg::AR_POS), 0); chk(q, 12);
    for (int i = 0; i < 3; i++) begin
      acc(1, pa(2, apc_pkg::AR_BLASH), bl[i]);
      go(2, 120);
      acc(0, pa(2, apc_pkg::AR_POS), 0); chk(q, 120);
      go(2, 110);
      acc(0, pa(2, apc_pkg::AR_POS), 0); chk(q, 110 + bl[i]);
    end
    acc(1, pa(0, apc_pkg::AR_MODE), 0);
    acc(1, pa(0, apc_pkg::AR_DISP), 32'h2401);
    repeat (4) @(posedge clk_sys);
    chk(disp[0].pos, 1110);
    chk(disp[0].coupled, 1);
    chk(disp[0].datum_ok, 1);
    go(2, 100);
    chk(disp[0].pos, 1100);
    acc(1, pa(0, apc_pkg::AR_DISP), 32'h2C01);
    repeat (4) @(posedge clk_sys);
    chk(disp[0].pos, 900);
    acc(1, apc_pkg::OFS_CTRL, 1);
    repeat (2) @(posedge clk_sys);
    chk(disp[2].blank, 1);
    acc(1, apc_pkg::OFS_CTRL, 3);
    key(0, HOLD + 8); chk(q & 7, 2);
    chk({disp[2].blank, disp[1].coupled, nv_last}, 32'hD);
    key(1, 3); chk(q & 7, 1);
    chk(disp[2].blank, 0);
    key(1, HOLD + 8); chk(q & 7, 4);
    chk({disp[1].blank, nv_last}, 32'h6);
    // factory default: request, refuse, request again, confirm
    acc(1, apc_pkg::OFS_CMD, 1);
    acc(0, apc_pkg::OFS_STATUS, 0);
    chk(q & 8, 8);
    acc(1, apc_pkg::OFS_CMD, 4);
    acc(0, apc_pkg::OFS_STATUS, 0);
    chk(q & 8, 0);
    acc(1, apc_pkg::OFS_CMD, 1);
    acc(1, apc_pkg::OFS_CMD, 2);
    acc(0, apc_pkg::OFS_STATUS, 0);
    chk(q & 15, 1);
    acc(0, pa(1, apc_pkg::AR_DISP), 0);
    chk(q, 32'h17);
    nv_cpl_in <= 2'h2;
    nrst <= 1'b0;
    repeat (16) @(posedge clk_sys);
    c = nv_cnt;
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    acc(0, apc_pkg::OFS_STATUS, 0); chk(q & 7, 4);
    chk(nv_cnt, c);
    results();
  end
endmodule
